// ===== verilog/encoder_sensor_control_status.sv
// sensor control word decode, preset sequencer, parking and error status
// Function
// - control word is 16 bits; bits 11..15 mode, preset, cyclic, park, ack
// - while parked stay on bus, sign-of-life runs, errors and diagnostics off
// - bits 11 and 12 drive preset; status bit 12 reports completion
// - preset value resets to zero, changed only by the parameter channel
// - control bit 11 zero selects absolute, one selects relative preset
// - relative preset shifts output position upward by the preset value
// - status 12 set after preset, cleared once controller drops request 12
// - each completed preset stores offset non-volatile, reloaded at power-up
// - control bit 13 adds current absolute position to second value word
// - parking request stops measurement monitoring and clears pending errors
// - parking while drive runs raises interface error, code 0x03 in word two
// - control bit 15 acknowledges the pending sensor error of status bit 15
// - status word is 16 bits; bits 11..15 ack, preset, cyclic, park, error
// - without status 13 or 15, second value word carries nothing valid
// - status bits 13 and 15 never set together
// - without error, word two is position while bit 13 set, else zero
// - without compatibility mode, control word evaluated only with PLC bit
`timescale 1ns/1ps
module encoder_sensor_control_status
  import encoder_sensor_pkg::*;
#(
  parameter int POS_BITS   = encoder_sensor_pkg::POS_W,
  parameter int NV_DEPTH   = 2
) (
  // clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  rst_n,
  // cyclic words from the controller
  input  wire logic [encoder_sensor_pkg::WORD_W-1:0] sensorControlWord,
  input  wire logic [encoder_sensor_pkg::WORD_W-1:0] encoderControlWordTwo,
  input  wire logic                                  compatMode,
  // parameter channel
  input  wire logic                                  presetValueWrite,
  input  wire logic [POS_BITS-1:0]                   presetValueParameter,
  // measurement side
  input  wire logic [POS_BITS-1:0]                   rawPosition,
  input  wire logic                                  driveRunning,
  input  wire logic                                  errorEvent,
  input  wire logic [encoder_sensor_pkg::CODE_W-1:0] errorEventCode,
  // cyclic words to the controller
  output logic      [encoder_sensor_pkg::WORD_W-1:0] sensorStatusWord,
  output logic      [POS_BITS-1:0]                   positionValueOne,
  output logic      [POS_BITS-1:0]                   positionValueTwo,
  // side controls
  output logic                                       monitorEnable,
  output logic                                       diagEnable,
  output logic                                       presetBusy
);

  import encoder_sensor_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (POS_BITS != POS_W || NV_DEPTH < 2) begin : g_bad_param
    $error("encoder_sensor_control_status: POS_BITS must equal POS_W, NV_DEPTH >= 2");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // modular add, used for output position and relative shift alike
  function automatic logic [POS_BITS-1:0] posAdd(input logic [POS_BITS-1:0] a,
                                                 input logic [POS_BITS-1:0] b);
    posAdd = a + b;
  endfunction : posAdd

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  preset_state_t             state_reg;
  preset_state_t             state_next;
  logic [WORD_W-1:0]         control_reg;
  logic [POS_BITS-1:0]       preset_reg;
  logic [POS_BITS-1:0]       offset_reg;
  logic [POS_BITS-1:0]       offset_next;
  logic                      error_reg;
  logic                      error_next;
  logic [CODE_W-1:0]         errCode_reg;
  logic [CODE_W-1:0]         errCode_next;
  logic                      ackSeen_reg;
  logic                      ackSeen_next;
  logic                      park_reg;
  logic                      park_next;
  logic [WORD_W-1:0]         status_reg;
  logic [WORD_W-1:0]         status_next;
  logic [POS_BITS-1:0]       pos1_reg;
  logic [POS_BITS-1:0]       pos2_reg;
  logic [POS_BITS-1:0]       pos2_next;
  logic [POS_BITS-1:0]       nvReadData;

  // ----------------------------------------------------------------
  // control word evaluation gate
  // ----------------------------------------------------------------
  // when the gate is shut the last evaluated word is held, so a lapse of
  // control does not look to the sequencer like a dropped request
  wire ctlEnable  = compatMode | encoderControlWordTwo[ECW2_PLC_CTRL];
  wire [WORD_W-1:0] ctlWord = ctlEnable ? sensorControlWord : control_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= '0;
    end else begin
      control_reg <= ctlWord;
    end
  end

  // decoded request bits; bits 0..10 carry nothing here
  wire homeMode  = ctlWord[CTL_HOME_MODE];
  wire presetReq = ctlWord[CTL_PRESET];
  wire cyclicReq = ctlWord[CTL_CYCLIC];
  wire parkReq   = ctlWord[CTL_PARK];
  wire ackReq    = ctlWord[CTL_ACK];

  // ----------------------------------------------------------------
  // preset value held for the parameter channel only
  // ----------------------------------------------------------------
  // the cyclic control word has no path into this register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      preset_reg <= PRESET_RESET;
    end else if (presetValueWrite) begin
      preset_reg <= presetValueParameter;
    end
  end

  // ----------------------------------------------------------------
  // preset sequencer
  // ----------------------------------------------------------------
  wire inLoadRd  = (state_reg == ST_LOAD_RD);
  wire inLoadCap = (state_reg == ST_LOAD_CAP);
  wire inApply   = (state_reg == ST_APPLY);
  wire inSave    = (state_reg == ST_SAVE);
  wire inDone    = (state_reg == ST_DONE);

  // absolute: offset chosen so raw + offset equals the preset value
  wire [POS_BITS-1:0] absOffset = preset_reg - rawPosition;
  // relative: existing offset grows by the preset value
  wire [POS_BITS-1:0] relOffset = posAdd(offset_reg, preset_reg);

  // next state; the request is a level, so DONE waits for it to drop
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOAD_RD:  state_next = ST_LOAD_CAP;
      ST_LOAD_CAP: state_next = ST_IDLE;
      ST_IDLE:     if (presetReq) begin
        state_next = ST_APPLY;
      end
      ST_APPLY:    state_next = ST_SAVE;
      ST_SAVE:     state_next = ST_DONE;
      ST_DONE:     if (!presetReq) begin
        state_next = ST_IDLE;
      end
      default:     state_next = ST_IDLE;
    endcase
  end

  // offset update: power-up reload or preset calculation
  always_comb begin
    offset_next = offset_reg;
    if (inLoadCap) begin
      offset_next = nvReadData;
    end else if (inApply) begin
      offset_next = (homeMode == HOME_RELATIVE) ? relOffset : absOffset;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_LOAD_RD;
      offset_reg <= OFFSET_RESET;
    end else begin
      state_reg  <= state_next;
      offset_reg <= offset_next;
    end
  end

  // ----------------------------------------------------------------
  // offset storage that outlives supply
  // ----------------------------------------------------------------
  // slot 0 holds the offset; write happens once per completed preset
  nv_offset_store #(
    .WIDTH (POS_BITS),
    .DEPTH (NV_DEPTH)
  ) u_nv_store (
    .clock     (clock),
    .rst_n     (rst_n),
    .writeEn   (inSave),
    .readEn    (inLoadRd),
    .addr      ('0),
    .writeData (offset_reg),
    .readData  (nvReadData)
  );

  // ----------------------------------------------------------------
  // parking and sensor error
  // ----------------------------------------------------------------
  // parking is refused while the drive turns; the refusal is itself an error
  wire parkIllegal = parkReq & driveRunning;
  wire parkOk      = parkReq & ~driveRunning;

  // errors from measurement are muted while parked
  wire errSet   = parkIllegal | (errorEvent & ~park_reg & ~parkOk);
  wire [CODE_W-1:0] errSetCode = parkIllegal ? ERR_SENSOR_IF : errorEventCode;

  // a new error wins over a clear in the same cycle
  always_comb begin
    error_next   = error_reg;
    errCode_next = errCode_reg;
    if (parkOk || ackReq) begin
      error_next = 1'b0;
    end
    if (errSet) begin
      error_next   = 1'b1;
      errCode_next = errSetCode;
    end
  end

  // acknowledge seen: raised while an error is acked, drops with the ack bit
  always_comb begin
    ackSeen_next = ackSeen_reg;
    if (!ackReq) begin
      ackSeen_next = 1'b0;
    end else if (error_reg) begin
      ackSeen_next = 1'b1;
    end
  end

  always_comb begin
    park_next = parkOk;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      error_reg   <= 1'b0;
      errCode_reg <= '0;
      ackSeen_reg <= 1'b0;
      park_reg    <= 1'b0;
    end else begin
      error_reg   <= error_next;
      errCode_reg <= errCode_next;
      ackSeen_reg <= ackSeen_next;
      park_reg    <= park_next;
    end
  end

  // ----------------------------------------------------------------
  // status word and position words
  // ----------------------------------------------------------------
  // error takes word two first, so cyclic transmit yields to it
  wire cyclicOn = cyclicReq & ~error_next;

  always_comb begin
    status_next               = STATUS_RESET;  // unused and reserved bits read 0
    status_next[STS_ACK_SEEN] = ackSeen_next;
    status_next[STS_PRESET]   = (state_next == ST_DONE);
    status_next[STS_CYCLIC]   = cyclicOn;
    status_next[STS_PARK]     = park_next;
    status_next[STS_ERROR]    = error_next;
  end

  // word two: error code, else position on request, else zero
  always_comb begin
    pos2_next = '0;
    if (error_next) begin
      pos2_next = {{(POS_BITS-CODE_W){1'b0}}, errCode_next};
    end else if (cyclicOn) begin
      pos2_next = posAdd(rawPosition, offset_next);
    end
  end

  // status word and both position words come from these flops; word one tracks the shifted position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= STATUS_RESET;
      pos1_reg   <= '0;
      pos2_reg   <= '0;
    end else begin
      status_reg <= status_next;
      pos1_reg   <= posAdd(rawPosition, offset_next);
      pos2_reg   <= pos2_next;
    end
  end

  // side enables; sign-of-life lives elsewhere and is not touched by parking
  logic monitor_reg;
  logic diag_reg;
  logic busy_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      monitor_reg <= 1'b0;
      diag_reg    <= 1'b0;
      busy_reg    <= 1'b1;
    end else begin
      monitor_reg <= ~park_next;
      diag_reg    <= ~park_next;
      busy_reg    <= ~(state_next == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sensorStatusWord = status_reg;
  assign positionValueOne = pos1_reg;
  assign positionValueTwo = pos2_reg;
  assign monitorEnable    = monitor_reg;
  assign diagEnable       = diag_reg;
  assign presetBusy       = busy_reg;

endmodule : encoder_sensor_control_status

// ===== verilog/encoder_sensor_pkg.sv
// shared constants and types for the sensor control and status block
package encoder_sensor_pkg;

  // ----------------------------------------------------------------
  // word widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int POS_W  = 32;
  localparam int CODE_W = 8;

  // ----------------------------------------------------------------
  // sensor control word fields
  // ----------------------------------------------------------------
  localparam int CTL_HOME_MODE = 11;
  localparam int CTL_PRESET    = 12;
  localparam int CTL_CYCLIC    = 13;
  localparam int CTL_PARK      = 14;
  localparam int CTL_ACK       = 15;

  // ----------------------------------------------------------------
  // sensor status word fields
  // ----------------------------------------------------------------
  localparam int STS_ACK_SEEN  = 11;
  localparam int STS_PRESET    = 12;
  localparam int STS_CYCLIC    = 13;
  localparam int STS_PARK      = 14;
  localparam int STS_ERROR     = 15;

  // ----------------------------------------------------------------
  // encoder control word two fields
  // ----------------------------------------------------------------
  localparam int ECW2_PLC_CTRL = 10;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] ERR_SENSOR_IF   = 8'h03;
  localparam logic [POS_W-1:0]  PRESET_RESET    = 32'h0000_0000;
  localparam logic [POS_W-1:0]  OFFSET_RESET    = 32'h0000_0000;
  localparam logic [WORD_W-1:0] STATUS_RESET    = 16'h0000;
  localparam logic              HOME_ABSOLUTE   = 1'b0;
  localparam logic              HOME_RELATIVE   = 1'b1;

  // ----------------------------------------------------------------
  // preset sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_LOAD_RD  = 6'b000001,
    ST_LOAD_CAP = 6'b000010,
    ST_IDLE     = 6'b000100,
    ST_APPLY    = 6'b001000,
    ST_SAVE     = 6'b010000,
    ST_DONE     = 6'b100000
  } preset_state_t;

endpackage : encoder_sensor_pkg

// ===== verilog/nv_offset_store.sv
// small store that keeps the preset offset across power cycles
`timescale 1ns/1ps
module nv_offset_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // access port
  input  wire logic                     writeEn,
  input  wire logic                     readEn,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         writeData,
  output logic      [WIDTH-1:0]         readData
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_param
    $error("nv_offset_store: WIDTH must be >= 1 and DEPTH >= 2");
  end

  // cells carry no reset on purpose: they model storage that outlives supply
  logic [WIDTH-1:0] cells [DEPTH];

  // write port
  always_ff @(posedge clock) begin
    if (writeEn) begin
      cells[addr] <= writeData;
    end
  end

  // registered read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData <= '0;
    end else if (readEn) begin
      readData <= cells[addr];
    end
  end

endmodule : nv_offset_store

// ===== sim/encoder_sensor_control_status_chk.sv
// concurrent checks on the sensor control and status ports
`timescale 1ns/1ps
module encoder_sensor_control_status_chk
  import encoder_sensor_pkg::*;
#(
  parameter int POS_BITS = encoder_sensor_pkg::POS_W
) (
  // clock and reset
  input wire logic                                  clock,
  input wire logic                                  rst_n,
  // controller and measurement side
  input wire logic [encoder_sensor_pkg::WORD_W-1:0] sensorControlWord,
  input wire logic [encoder_sensor_pkg::WORD_W-1:0] encoderControlWordTwo,
  input wire logic                                  compatMode,
  input wire logic                                  driveRunning,
  input wire logic                                  errorEvent,
  // encoder outputs
  input wire logic [encoder_sensor_pkg::WORD_W-1:0] sensorStatusWord,
  input wire logic [POS_BITS-1:0]                   positionValueOne,
  input wire logic [POS_BITS-1:0]                   positionValueTwo,
  input wire logic                                  monitorEnable,
  input wire logic                                  diagEnable,
  input wire logic                                  presetBusy
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [WORD_W-1:0] ctl;
  logic [WORD_W-1:0] sts;
  logic              gateOpen;

  // short aliases; the gate decides whether the control word counts
  assign ctl      = sensorControlWord;
  assign sts      = sensorStatusWord;
  assign gateOpen = compatMode | encoderControlWordTwo[ECW2_PLC_CTRL];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // a preset is taken only by an idle sequencer with the gate open
  sequence presetAsk;
    !presetBusy && gateOpen && ctl[CTL_PRESET] && !sts[STS_PRESET];
  endsequence
  sequence presetShown;
    ##[2:3] sts[STS_PRESET];
  endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_status_excl: assert property (!(sts[STS_CYCLIC] && sts[STS_ERROR]))
    else $error("cyclic and error status set together");
  chk_unused_zero: assert property (sts[10:0] == 11'h000)
    else $error("unused status bits not zero");
  chk_word_idle: assert property (!sts[STS_CYCLIC] && !sts[STS_ERROR] |->
    positionValueTwo == '0) else $error("word two not zero when idle");
  chk_cyclic_follow: assert property (gateOpen && !errorEvent && !sts[STS_ERROR] &&
    !ctl[CTL_PARK] |=> sts[STS_CYCLIC] == $past(ctl[CTL_CYCLIC]))
    else $error("cyclic status does not follow request");
  chk_cyclic_pos: assert property (sts[STS_CYCLIC] && !presetBusy |->
    positionValueTwo == positionValueOne) else $error("word two not the position");
  chk_preset_done: assert property (presetAsk |-> presetShown)
    else $error("preset completion not shown");
  chk_preset_hold: assert property (sts[STS_PRESET] && gateOpen && ctl[CTL_PRESET]
    |=> sts[STS_PRESET]) else $error("preset status dropped early");
  chk_preset_end: assert property (sts[STS_PRESET] && gateOpen && !ctl[CTL_PRESET]
    |=> !sts[STS_PRESET]) else $error("preset status not ended");
  chk_park_quiet: assert property (gateOpen && ctl[CTL_PARK] && !driveRunning |=>
    sts[STS_PARK] && !sts[STS_ERROR] && !monitorEnable && !diagEnable)
    else $error("parking not entered cleanly");
  chk_park_fault: assert property (gateOpen && ctl[CTL_PARK] && driveRunning &&
    !errorEvent && !sts[STS_ERROR] |=> sts[STS_ERROR] && !sts[STS_PARK] &&
    positionValueTwo == POS_BITS'(ERR_SENSOR_IF)) else $error("running park not refused");
  chk_ack_clear: assert property (gateOpen && ctl[CTL_ACK] && sts[STS_ERROR] &&
    !errorEvent && !ctl[CTL_PARK] |=> !sts[STS_ERROR] && sts[STS_ACK_SEEN])
    else $error("acknowledge did not clear error");
endmodule : encoder_sensor_control_status_chk

bind encoder_sensor_control_status encoder_sensor_control_status_chk #(
  .POS_BITS(POS_BITS)
) encoder_sensor_control_status_chk_i (
  .clock, .rst_n, .sensorControlWord, .encoderControlWordTwo, .compatMode,
  .driveRunning, .errorEvent, .sensorStatusWord, .positionValueOne,
  .positionValueTwo, .monitorEnable, .diagEnable, .presetBusy
);

// ===== sim/plc_controller_model.sv
// controller model that sends the cyclic control words
`timescale 1ns/1ps
module plc_controller_model
  import encoder_sensor_pkg::*;
(
  // clock
  input  wire logic                                  clock,
  // status from the encoder
  input  wire logic [encoder_sensor_pkg::WORD_W-1:0] sensorStatusWord,
  // words to the encoder
  output logic      [encoder_sensor_pkg::WORD_W-1:0] sensorControlWord,
  output logic      [encoder_sensor_pkg::WORD_W-1:0] encoderControlWordTwo
);
  // ------------------------------------------------------------
  // word sources
  // ------------------------------------------------------------
  // unused and reserved bits stay zero; control by the controller on
  initial begin
    sensorControlWord     = 16'h0000;
    encoderControlWordTwo = 16'h0400;
  end

  // one control bit, changed just after a falling edge
  task automatic put_bit(input int idx, input logic val);
    @(negedge clock);
    sensorControlWord[idx] = val;
  endtask : put_bit

  // opens or shuts the gate on the control word
  task automatic plc_ctrl(input logic val);
    @(negedge clock);
    encoderControlWordTwo[ECW2_PLC_CTRL] = val;
  endtask : plc_ctrl

  // request held until the encoder answers, then withdrawn
  task automatic preset(input logic relMode, output logic ok);
    int n;
    n = 0;
    @(negedge clock);
    sensorControlWord[CTL_HOME_MODE] = relMode;
    sensorControlWord[CTL_PRESET]    = 1'b1;
    while (sensorStatusWord[STS_PRESET] !== 1'b1 && n < 16) begin
      @(negedge clock);
      n++;
    end
    sensorControlWord[CTL_PRESET] = 1'b0;
    while (sensorStatusWord[STS_PRESET] !== 1'b0 && n < 32) begin
      @(negedge clock);
      n++;
    end
    ok = (n > 1 && n < 12);
  endtask : preset
endmodule : plc_controller_model

// ===== sim/encoder_sensor_control_status_test.sv
// self-checking bench for the sensor control and status block
`timescale 1ns/1ps
module encoder_sensor_control_status_test;
  import encoder_sensor_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              clock, rst_n, compatMode, driveRunning, presetValueWrite;
  logic              errorEvent, monitorEnable, diagEnable, presetBusy, ok;
  logic [WORD_W-1:0] sensorControlWord, encoderControlWordTwo, sensorStatusWord;
  logic [POS_W-1:0]  presetValueParameter, rawPosition, positionValueOne;
  logic [POS_W-1:0]  positionValueTwo, offModel, presetVal;
  logic [CODE_W-1:0] errorEventCode;
  logic [POS_W:0]    expQ[$];
  logic              prevDone = 1'b0, prevErr = 1'b0;
  int                err_total = 0, n_compared = 0;
  int                seed = 32'he7a6;

  encoder_sensor_control_status encoder_sensor_control_status_i (
    .clock, .rst_n, .sensorControlWord, .encoderControlWordTwo, .compatMode,
    .presetValueWrite, .presetValueParameter, .rawPosition, .driveRunning,
    .errorEvent, .errorEventCode, .sensorStatusWord, .positionValueOne,
    .positionValueTwo, .monitorEnable, .diagEnable, .presetBusy
  );
  plc_controller_model plc_controller_model_i (
    .clock, .sensorStatusWord, .sensorControlWord, .encoderControlWordTwo
  );

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic check(input logic [POS_W-1:0] exp, input logic [POS_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // oldest note against a result; an empty queue forces a mismatch
  task automatic take(input logic sel, input logic [POS_W-1:0] got);
    logic [POS_W:0] note;
    if (expQ.size() > 0) note = expQ.pop_front();
    else note = {~sel, ~got};
    check({31'h0, sel}, {31'h0, note[POS_W]});
    check(note[POS_W-1:0], got);
  endtask : take

  // bounded wait; the sequencer reloads the offset after reset
  task automatic wait_idle();
    int n;
    n = 0;
    while (presetBusy !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    check(32'h0, {31'h0, presetBusy});
  endtask : wait_idle

  // the expected offset is modelled before the request goes out
  task automatic run_preset(input logic relMode);
    if (relMode) offModel = offModel + presetVal;
    else offModel = presetVal - rawPosition;
    expQ.push_back({1'b0, rawPosition + offModel});
    plc_controller_model_i.preset(relMode, ok);
    check(32'h1, {31'h0, ok});
  endtask : run_preset

  // one-cycle error pulse; a note only where the error must show
  task automatic raise_error(input logic noted);
    errorEventCode = 8'($random(seed)) | 8'h80;
    if (noted) expQ.push_back({1'b1, 24'h0, errorEventCode});
    errorEvent = 1'b1;
    tick(1);
    errorEvent = 1'b0;
  endtask : raise_error

  task automatic ack_error();
    plc_controller_model_i.put_bit(CTL_ACK, 1'b1);
    tick(1);
    check(32'h0800, {16'h0, sensorStatusWord & 16'h8800});
    plc_controller_model_i.put_bit(CTL_ACK, 1'b0);
  endtask : ack_error

  // ------------------------------------------------------------
  // result watcher
  // ------------------------------------------------------------
  // preset completions and newly raised errors take the oldest note
  always @(negedge clock) begin
    if (rst_n === 1'b1 && sensorStatusWord[STS_PRESET] === 1'b1 && !prevDone)
      take(1'b0, positionValueOne);
    if (rst_n === 1'b1 && sensorStatusWord[STS_ERROR] === 1'b1 && !prevErr)
      take(1'b1, positionValueTwo);
    prevDone = (sensorStatusWord[STS_PRESET] === 1'b1);
    prevErr  = (sensorStatusWord[STS_ERROR] === 1'b1);
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    compatMode = 1'b0;
    driveRunning = 1'b0;
    presetValueWrite = 1'b0;
    errorEvent = 1'b0;
    errorEventCode = 8'h00;
    presetValueParameter = 32'h0000_0000;
    presetVal = 32'h0000_0000;
    offModel = 32'h0000_0000;
    rawPosition = $random(seed);
    tick(2);
    rst_n = 1'b1;
    wait_idle();
    run_preset(1'b0); // preset register starts at zero
    presetVal = $random(seed);
    presetValueParameter = presetVal;
    presetValueWrite = 1'b1;
    tick(1);
    presetValueWrite = 1'b0;
    presetValueParameter = $random(seed); // not written, so must not count
    run_preset(1'b0);
    rawPosition = $random(seed);
    run_preset(1'b1);
    run_preset(1'b1); // back to back
    // second reset: the stored offset must come back
    rst_n = 1'b0;
    tick(2);
    check(32'h0, {16'h0, sensorStatusWord});
    rst_n = 1'b1;
    wait_idle();
    tick(1);
    check(rawPosition + offModel, positionValueOne);
    // cyclic position, then the gate shut and reopened by compat mode
    plc_controller_model_i.put_bit(CTL_CYCLIC, 1'b1);
    tick(2);
    check(32'h2000, {16'h0, sensorStatusWord});
    check(rawPosition + offModel, positionValueTwo);
    plc_controller_model_i.plc_ctrl(1'b0);
    plc_controller_model_i.put_bit(CTL_CYCLIC, 1'b0);
    tick(2);
    check(32'h1, {31'h0, sensorStatusWord[STS_CYCLIC]});
    compatMode = 1'b1;
    tick(2);
    check(32'h0, positionValueTwo);
    plc_controller_model_i.plc_ctrl(1'b1);
    compatMode = 1'b0;
    // error while cyclic, then acknowledged
    plc_controller_model_i.put_bit(CTL_CYCLIC, 1'b1);
    raise_error(1'b1);
    tick(1);
    check(32'h0, {31'h0, sensorStatusWord[STS_CYCLIC]});
    ack_error();
    plc_controller_model_i.put_bit(CTL_CYCLIC, 1'b0);
    // parking refused while the drive runs
    driveRunning = 1'b1;
    expQ.push_back({1'b1, 32'h0000_0003});
    plc_controller_model_i.put_bit(CTL_PARK, 1'b1);
    tick(2);
    check(32'h0, {31'h0, sensorStatusWord[STS_PARK]});
    plc_controller_model_i.put_bit(CTL_PARK, 1'b0);
    driveRunning = 1'b0;
    ack_error();
    // parking clears a pending error and silences new ones
    raise_error(1'b1);
    tick(1);
    plc_controller_model_i.put_bit(CTL_PARK, 1'b1);
    tick(1);
    check(32'h4000, {16'h0, sensorStatusWord});
    check(32'h0, {30'h0, monitorEnable, diagEnable});
    raise_error(1'b0);
    tick(2);
    check(32'h4000, {16'h0, sensorStatusWord});
    plc_controller_model_i.put_bit(CTL_PARK, 1'b0);
    tick(2);
    check(32'h3, {30'h0, monitorEnable, diagEnable});
    check(32'h0, expQ.size());
    stop_test();
  end

  // cut a hang short; the whole run needs fewer than a hundred cycles
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule : encoder_sensor_control_status_test
